// ### hdl/config_lock_regs.sv
// register bank: pump, lock, pin mode and switch duty/rate
//
// Functional notes
// R1: three-bit pump rate, 010 default 2.2 MHz
// R2: one bit picks low or high threshold
// R3: two-bit spread rate, 00 disables spreading
// R4: reserved bits always read back zero
// R5: level-1 lock freezes lockable bits until power-up
// R6: lock engages on chip select rising edge
// R7: lock survives soft reset, cleared at power-on
// R8: locked registers keep values through soft reset
// R9: restart keeps configured value, power-up loads default
// R10: pin mode selects fail, timer, off, switches
// R11: wake input mode uses 16 us filter
// R12: pin mode restart value follows current mode
// R13: wake pin is fail-safe wake source
// R14: duty 00 off, FF on, else value/255
// R15: new duty applies at period end
// R16: host writes duty before enabling switch mode
// R17: rate code selects 100/200/325/400 Hz
// R18: new rate applies at period end
// R19: hardware config powers up 40, bit1 clear
// R20: duty, rate cleared; restart keeps duty, rate bit0
// R21: level-0 lock freezes pin mode field
// R22: written settings take effect on chip select rise
// R23: locked writes ignored silently, old value read
// R24: host never writes reserved pump rate codes
`default_nettype none
module config_lock_regs
  import cfg_regs_pkg::*;
#(
  // cycles per duty step for each rate code
  parameter int unsigned STEP_CYC0 = STEP_CYC_F0,
  parameter int unsigned STEP_CYC1 = STEP_CYC_F1,
  parameter int unsigned STEP_CYC2 = STEP_CYC_F2,
  parameter int unsigned STEP_CYC3 = STEP_CYC_F3
) (
  input  wire logic       CLOCK,           // 200 MHz
  input  wire logic       RESET,           // power-on, sync
  input  wire logic       RESTART,         // restart entry pulse
  input  wire logic       SOFT_RESET,      // soft reset pulse
  input  wire logic       FAIL_SAFE_MODE,  // device in fail-safe
  input  wire logic       LEVEL0_LOCK,     // level-0 lock bit
  input  wire logic       CHIP_SELECT_N,   // serial select pin
  input  wire logic       FRAME_VALID,     // decoded frame pulse
  input  wire logic       FRAME_WRITE,     // frame is a write
  input  wire logic [6:0] FRAME_ADDR,      // register address
  input  wire logic [7:0] FRAME_DATA,      // write data byte
  input  wire logic       MPP_PIN_IN,      // multi-purpose pin
  output logic [7:0]      READ_DATA,       // read answer byte
  output logic [2:0]      PUMP_SWITCH_RATE_SEL,
  output logic            REGULATOR_PEAK_THRESHOLD_SEL,
  output logic [1:0]      SPREAD_MODULATION_RATE,
  output logic            LEVEL1_LOCKED,
  output logic [2:0]      PIN_MODE,
  output logic            FAIL_OUTPUT_EN,
  output logic            TIMER_SWITCH_EN,
  output logic            WAKE_INPUT_EN,
  output logic            HIGH_SIDE_SWITCH_ON,
  output logic            LOW_SIDE_SWITCH_ON,
  output logic            WAKE_EVENT,
  output logic            FAIL_SAFE_WAKE
);

  // ==========================================================
  // declarations
  logic       cs_s1_r;      // first stage, feeds cs_s2_r only
  logic       cs_s2_r;      // synchronised select
  logic       cs_d_r;       // delayed copy for edge detect
  logic       mpp_s1_r;     // first stage, feeds mpp_s2_r only
  logic       mpp_s2_r;     // synchronised pin level
  logic       cs_rise;      // end of a frame
  logic       pend_valid_r; // a write waits for select rise
  logic [6:0] pend_addr_r;
  logic [7:0] pend_data_r;
  logic [7:0] hw2_r;        // pump, threshold, spread, lock
  logic [2:0] pin_mode_r;
  logic [7:0] duty_r;
  logic [1:0] rate_r;
  logic [7:0] read_data_r;
  logic [7:0] rd_val;       // read mux output
  logic       lock1;        // level-1 lock engaged
  logic       cfg_reset;    // restart or soft reset
  logic       commit;       // pending write lands now
  logic       hw2_we;
  logic       pin_we;
  logic       duty_we;
  logic       rate_we;
  logic       pwm_run;
  logic       pwm_on;
  logic       wake_en;
  logic [11:0] filt_cnt_r;  // wake filter stability count
  logic       mpp_filt_r;   // filtered pin level
  logic       wake_evt_r;
  logic       fs_wake_r;
  logic       fail_out_r;
  logic       timer_en_r;
  logic       wake_en_r;
  logic       hs_on_r;
  logic       ls_on_r;

  // ==========================================================
  // helpers
  // timer and switch modes fall back to off on restart; the rest keep
  function automatic logic [2:0] pin_restart(input logic [2:0] m);
    if (m == MODE_TIMER_HS || m == MODE_PWM_LS || m == MODE_PWM_HS)
      return MODE_OFF;
    return m;
  endfunction : pin_restart

  // ==========================================================
  // synchronisers for the select and multi-purpose pins
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      cs_d_r   <= 1'b1;
      mpp_s1_r <= 1'b0;
      mpp_s2_r <= 1'b0;
    end else begin
      cs_s1_r  <= CHIP_SELECT_N;
      cs_s2_r  <= cs_s1_r;
      cs_d_r   <= cs_s2_r;
      mpp_s1_r <= MPP_PIN_IN;
      mpp_s2_r <= mpp_s1_r;
    end
  end

  // low to high on select closes the frame
  assign cs_rise = cs_s2_r & ~cs_d_r;

  // ==========================================================
  // pending write, held until the frame ends
  // one slot is enough: a frame carries one register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pend_valid_r <= 1'b0;
      pend_addr_r  <= 7'h00;
      pend_data_r  <= 8'h00;
    end else if (cfg_reset) begin
      pend_valid_r <= 1'b0;  // writes lost across a reset
    end else if (FRAME_VALID && FRAME_WRITE) begin
      pend_valid_r <= 1'b1;
      pend_addr_r  <= FRAME_ADDR;
      pend_data_r  <= FRAME_DATA;
    end else if (cs_rise) begin
      pend_valid_r <= 1'b0;
    end
  end

  // ==========================================================
  // write strobes
  assign cfg_reset = RESTART | SOFT_RESET;
  assign lock1     = hw2_r[LOCK1_BIT];
  assign commit    = cs_rise & pend_valid_r & ~cfg_reset;  // R22
  // locked targets simply drop the write, no error flag
  assign hw2_we  = commit & (pend_addr_r == ADDR_HW_CFG2)
                   & ~lock1;  // R5 R23
  assign pin_we  = commit & (pend_addr_r == ADDR_PIN_MODE)
                   & ~LEVEL0_LOCK;  // R21 R23
  assign duty_we = commit & (pend_addr_r == ADDR_SW_DUTY);
  assign rate_we = commit & (pend_addr_r == ADDR_SW_RATE);

  // ==========================================================
  // hardware config: pump rate, threshold, spread, lock
  // restart and soft reset leave it alone; bit 1 never stored,
  // so the restart value with bit 1 clear holds by itself
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      hw2_r <= HW_CFG2_POR;  // R19 R7
    end else if (hw2_we) begin  // R8
      hw2_r <= pend_data_r & HW_CFG2_MASK;  // R6 R4
    end
  end

  // field outputs straight from the register
  assign PUMP_SWITCH_RATE_SEL = hw2_r[PUMP_RATE_LSB +: 3];  // R1
  assign REGULATOR_PEAK_THRESHOLD_SEL = hw2_r[PEAK_BIT];    // R2
  assign SPREAD_MODULATION_RATE = hw2_r[SPREAD_LSB +: 2];   // R3
  assign LEVEL1_LOCKED = lock1;

  // ==========================================================
  // pin mode field
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pin_mode_r <= PIN_MODE_POR;
    end else if (cfg_reset) begin
      pin_mode_r <= pin_restart(pin_mode_r);  // R12 R9
    end else if (pin_we) begin
      pin_mode_r <= pend_data_r[2:0];
    end
  end

  // ==========================================================
  // duty and rate: cleared by soft reset without restart; restart keeps duty and rate bit 0, clears rate bit 1
  always_ff @(posedge CLOCK) begin
    if (RESET || (SOFT_RESET && !RESTART)) begin
      duty_r <= SW_DUTY_POR;  // R20
    end else if (duty_we) begin
      duty_r <= pend_data_r;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET || (SOFT_RESET && !RESTART)) begin
      rate_r <= SW_RATE_POR;  // R20
    end else if (RESTART) begin
      rate_r <= {1'b0, rate_r[0]};  // R20
    end else if (rate_we) begin
      rate_r <= pend_data_r[1:0];
    end
  end

  // ==========================================================
  // read path: committed values, reserved bits as zero
  always_comb begin
    rd_val = 8'h00;  // unmapped address
    if (FRAME_ADDR == ADDR_HW_CFG2) begin
      rd_val = hw2_r & HW_CFG2_MASK;  // R4
    end else if (FRAME_ADDR == ADDR_PIN_MODE) begin
      rd_val = {5'h00, pin_mode_r};   // R4
    end else if (FRAME_ADDR == ADDR_SW_DUTY) begin
      rd_val = duty_r;
    end else if (FRAME_ADDR == ADDR_SW_RATE) begin
      rd_val = {6'h00, rate_r};       // R4
    end
  end

  // answer latched with the frame, held until the next one
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      read_data_r <= 8'h00;
    end else if (FRAME_VALID) begin
      read_data_r <= rd_val;  // R23
    end
  end

  assign READ_DATA = read_data_r;
  assign PIN_MODE  = pin_mode_r;

  // ==========================================================
  // pulse-width generator
  assign pwm_run = (pin_mode_r == MODE_PWM_LS)
                 | (pin_mode_r == MODE_PWM_HS);

  switch_pwm_gen #(
    .STEP0 (STEP_CYC0),
    .STEP1 (STEP_CYC1),
    .STEP2 (STEP_CYC2),
    .STEP3 (STEP_CYC3)
  ) u_pwm (
    .clk    (CLOCK),
    .rst    (RESET),
    .run    (pwm_run),
    .duty   (duty_r),
    .rate   (rate_r),
    .pwm_on (pwm_on)
  );

  // ==========================================================
  // mode decode to pin drivers
  assign wake_en = (pin_mode_r == MODE_WAKE);

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      fail_out_r <= 1'b1;  // power-on mode is fail output
      timer_en_r <= 1'b0;
      wake_en_r  <= 1'b0;
      hs_on_r    <= 1'b0;
      ls_on_r    <= 1'b0;
    end else begin
      fail_out_r <= (pin_mode_r <= MODE_FAIL_MAX);           // R10
      timer_en_r <= (pin_mode_r == MODE_TIMER_HS);           // R10
      wake_en_r  <= wake_en;                                 // R10
      hs_on_r    <= (pin_mode_r == MODE_PWM_HS) && pwm_on;   // R10
      ls_on_r    <= (pin_mode_r == MODE_PWM_LS) && pwm_on;   // R10
    end
  end

  assign FAIL_OUTPUT_EN      = fail_out_r;
  assign TIMER_SWITCH_EN     = timer_en_r;
  assign WAKE_INPUT_EN       = wake_en_r;
  assign HIGH_SIDE_SWITCH_ON = hs_on_r;
  assign LOW_SIDE_SWITCH_ON  = ls_on_r;

  // ==========================================================
  // static wake filter: a new level must hold the full time
  // short glitches restart the count, so they never wake
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      filt_cnt_r <= 12'h000;
      mpp_filt_r <= 1'b0;
      wake_evt_r <= 1'b0;
    end else if (!wake_en || mpp_s2_r == mpp_filt_r) begin
      filt_cnt_r <= 12'h000;
      mpp_filt_r <= wake_en ? mpp_filt_r : mpp_s2_r;
      wake_evt_r <= 1'b0;
    end else if (filt_cnt_r == 12'(WAKE_FILT_CYC - 1)) begin
      filt_cnt_r <= 12'h000;
      mpp_filt_r <= mpp_s2_r;  // R11
      wake_evt_r <= 1'b1;
    end else begin
      filt_cnt_r <= filt_cnt_r + 12'h001;
      wake_evt_r <= 1'b0;
    end
  end

  // fail-safe wake follows the filtered event
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      fs_wake_r <= 1'b0;
    end else begin
      fs_wake_r <= wake_en && FAIL_SAFE_MODE
                   && mpp_s2_r != mpp_filt_r
                   && filt_cnt_r == 12'(WAKE_FILT_CYC - 1);  // R13
    end
  end

  assign WAKE_EVENT     = wake_evt_r;
  assign FAIL_SAFE_WAKE = fs_wake_r;

  // ==========================================================
  // checks
  default clocking dflt @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  sequence lock_write;
    commit && pend_addr_r == ADDR_HW_CFG2
      && pend_data_r[LOCK1_BIT] && !lock1;
  endsequence

  sequence duty_commit;
    duty_we ##1 1'b1;
  endsequence

  a_lock_engage: assert property ( // R6
    lock_write |=> lock1 ##1 lock1)
    else $error("lock not engaged after frame end");
  a_no_early_lock: assert property ( // R6
    !lock1 && !commit |=> !lock1)
    else $error("lock engaged without frame end");
  a_lock_freeze: assert property ( // R5
    lock1 |=> $stable(hw2_r) && lock1)
    else $error("locked config changed");
  a_pin_locked: assert property ( // R21
    LEVEL0_LOCK && !cfg_reset |=> $stable(pin_mode_r))
    else $error("pin mode changed under level-0 lock");
  a_reserved_read: assert property ( // R4
    FRAME_VALID && FRAME_ADDR == ADDR_SW_RATE
      |=> READ_DATA[7:2] == 6'h00)
    else $error("reserved rate bits read nonzero");
  a_cs_apply: assert property ( // R22
    !cs_rise && !cfg_reset |=> $stable(duty_r))
    else $error("duty changed outside frame end");
  a_duty_lands: assert property ( // R22
    duty_commit |-> duty_r == $past(pend_data_r))
    else $error("committed duty not stored");
  a_restart_keep: assert property ( // R20
    RESTART |=> $stable(duty_r) && !rate_r[1])
    else $error("restart altered duty or rate");
  a_soft_clear: assert property ( // R20
    SOFT_RESET && !RESTART
      |=> duty_r == SW_DUTY_POR && rate_r == SW_RATE_POR)
    else $error("soft reset left duty or rate");
  a_wake_filter: assert property ( // R11
    WAKE_EVENT |-> $past(filt_cnt_r) == 12'(WAKE_FILT_CYC - 1))
    else $error("wake event before filter time");
  a_fs_wake: assert property ( // R13
    FAIL_SAFE_WAKE |-> WAKE_EVENT && $past(FAIL_SAFE_MODE))
    else $error("fail-safe wake without wake event");
  a_hs_mode: assert property ( // R10
    HIGH_SIDE_SWITCH_ON |-> $past(pin_mode_r) == MODE_PWM_HS)
    else $error("high side on outside its mode");

endmodule : config_lock_regs
`default_nettype wire

// ### include/cfg_regs_pkg.sv
// constants for the pump, lock, pin mode and switch register bank
`default_nettype none
package cfg_regs_pkg;

  // ==========================================================
  // register offsets (serial port addresses)
  localparam logic [6:0] ADDR_HW_CFG2  = 7'h0F;
  localparam logic [6:0] ADDR_PIN_MODE = 7'h17;
  localparam logic [6:0] ADDR_SW_DUTY  = 7'h18;
  localparam logic [6:0] ADDR_SW_RATE  = 7'h1C;

  // ==========================================================
  // field positions inside the hardware config register
  localparam int PUMP_RATE_LSB = 5;  // three bits
  localparam int PEAK_BIT      = 4;
  localparam int SPREAD_LSB    = 2;  // two bits
  localparam int LOCK1_BIT     = 0;
  // bit 1 is reserved and never stored
  localparam logic [7:0] HW_CFG2_MASK = 8'hFD;

  // ==========================================================
  // power-on values
  localparam logic [7:0] HW_CFG2_POR  = 8'h40;
  localparam logic [2:0] PIN_MODE_POR = 3'h0;
  localparam logic [7:0] SW_DUTY_POR  = 8'h00;
  localparam logic [1:0] SW_RATE_POR  = 2'h0;

  // ==========================================================
  // pin mode codes
  localparam logic [2:0] MODE_FAIL_MAX = 3'h2;  // 000..010
  localparam logic [2:0] MODE_TIMER_HS = 3'h3;
  localparam logic [2:0] MODE_OFF      = 3'h4;
  localparam logic [2:0] MODE_WAKE     = 3'h5;
  localparam logic [2:0] MODE_PWM_LS   = 3'h6;
  localparam logic [2:0] MODE_PWM_HS   = 3'h7;

  // ==========================================================
  // timing
  localparam int CLK_MHZ       = 200;
  localparam int WAKE_FILT_US  = 16;
  localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;
  localparam int PWM_STEPS     = 255;
  localparam int PWM_HZ_F0     = 100;
  localparam int PWM_HZ_F1     = 200;
  localparam int PWM_HZ_F2     = 325;
  localparam int PWM_HZ_F3     = 400;
  localparam int STEP_CYC_F0 = (CLK_MHZ * 1000000) / (PWM_HZ_F0 * PWM_STEPS);
  localparam int STEP_CYC_F1 = (CLK_MHZ * 1000000) / (PWM_HZ_F1 * PWM_STEPS);
  localparam int STEP_CYC_F2 = (CLK_MHZ * 1000000) / (PWM_HZ_F2 * PWM_STEPS);
  localparam int STEP_CYC_F3 = (CLK_MHZ * 1000000) / (PWM_HZ_F3 * PWM_STEPS);

endpackage : cfg_regs_pkg
`default_nettype wire

// ### hdl/switch_pwm_gen.sv
// pulse-width timing generator for the multi-purpose switch
`default_nettype none
module switch_pwm_gen
  import cfg_regs_pkg::*;
#(
  parameter int unsigned STEP0 = STEP_CYC_F0,
  parameter int unsigned STEP1 = STEP_CYC_F1,
  parameter int unsigned STEP2 = STEP_CYC_F2,
  parameter int unsigned STEP3 = STEP_CYC_F3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] duty,
  input  wire logic [1:0] rate,
  output logic            pwm_on
);

  logic [23:0] tick_r;      // cycles inside one duty step
  logic [7:0]  step_r;      // step index, 0..254
  logic [7:0]  duty_act_r;  // duty of the running period
  logic [1:0]  rate_act_r;  // rate of the running period
  logic        pwm_on_r;
  logic [23:0] step_len;
  logic        step_end;
  logic        wrap;        // last cycle of a period

  // ==========================================================
  // step length from the active rate code
  assign step_len = (rate_act_r == 2'h0) ? 24'(STEP0) :  // R17
                    (rate_act_r == 2'h1) ? 24'(STEP1) :
                    (rate_act_r == 2'h2) ? 24'(STEP2) : 24'(STEP3);
  assign step_end = (tick_r == step_len - 24'h1);
  assign wrap     = step_end && (step_r == 8'(PWM_STEPS - 1));
  assign pwm_on   = pwm_on_r;

  // step and tick counters, parked while not running
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      tick_r <= 24'h0;
      step_r <= 8'h00;
    end else if (step_end) begin
      tick_r <= 24'h0;
      step_r <= wrap ? 8'h00 : step_r + 8'h01;
    end else begin
      tick_r <= tick_r + 24'h1;
    end
  end

  // new settings only at a period boundary or while idle
  always_ff @(posedge clk) begin
    if (rst) begin
      duty_act_r <= SW_DUTY_POR;
      rate_act_r <= SW_RATE_POR;
    end else if (!run || wrap) begin
      duty_act_r <= duty;  // R15
      rate_act_r <= rate;  // R18
    end
  end

  // on while step below duty: 00 never, FF always
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_on_r <= 1'b0;
    end else begin
      pwm_on_r <= run && (step_r < duty_act_r);  // R14
    end
  end

  // ==========================================================
  // checks
  default clocking dflt @(posedge clk);
  endclocking
  default disable iff (rst);

  a_duty_zero_off: assert property ( // R14
    run && duty_act_r == 8'h00 |=> !pwm_on)
    else $error("switch on with zero duty");
  a_duty_full_on: assert property ( // R14
    run && duty_act_r == 8'hFF |=> pwm_on)
    else $error("switch off with full duty");
  a_duty_mid_period: assert property ( // R15
    run && $past(run) && !wrap |=> $stable(duty_act_r))
    else $error("duty changed inside a period");

endmodule : switch_pwm_gen
`default_nettype wire

// ### verif/spi_host_model.sv
// host model: issues decoded register frames into the bank
`default_nettype none
module spi_host_model (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            fv,
  output logic            fw,
  output logic [6:0]      fa,
  output logic [7:0]      fd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle state: select released, no frame
  initial begin
    cs_n = 1'b1;
    fv   = 1'b0;
    fw   = 1'b0;
    fa   = 7'h00;
    fd   = 8'h00;
  end

  // one frame, then select rise so the bank commits it
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    fv   = 1'b1;
    fw   = w;
    fa   = a;
    fd   = d;
    @(negedge clk);
    fv   = 1'b0;
    // released lines show the inverse, never a stale match
    fw   = ~w;
    fa   = ~a;
    fd   = ~d;
    @(negedge clk);
    cs_n = 1'b1;
    // room for the two-stage select sync and commit
    repeat (5) @(negedge clk);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ### verif/test_config_lock_regs.sv
// self-checking bench for the config lock register bank
`default_nettype none
module test_config_lock_regs
  import cfg_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  localparam int STEPS[4] = '{4, 3, 2, 1};  // short step counts
  logic clock, reset, restart, soft_rst, fsafe, lock0, mpp, pend;
  wire logic       cs_n, fv, fw;
  wire logic [6:0] fa;
  wire logic [7:0] fd;
  logic [7:0] rd, v, k, hw;
  logic [2:0] prate, pmode;
  logic [1:0] spread;
  logic peak, lk1, fo, ts, wi, hs, ls, wev, fsw, seen;
  logic [7:0]  notes[$];                 // expected read bytes
  logic [31:0] seed = 32'h00005AB4;      // 23220
  int failures = 0, n_compared = 0, cycles = 0, n;

  spi_host_model host (.clk(clock), .cs_n(cs_n), .fv(fv), .fw(fw),
                       .fa(fa), .fd(fd));

  config_lock_regs #(
    .STEP_CYC0(STEPS[0]),
    .STEP_CYC1(STEPS[1]),
    .STEP_CYC2(STEPS[2]),
    .STEP_CYC3(STEPS[3])
  ) dut (
    .CLOCK(clock),
    .RESET(reset),
    .RESTART(restart),
    .SOFT_RESET(soft_rst),
    .FAIL_SAFE_MODE(fsafe),
    .LEVEL0_LOCK(lock0),
    .CHIP_SELECT_N(cs_n),
    .FRAME_VALID(fv),
    .FRAME_WRITE(fw),
    .FRAME_ADDR(fa),
    .FRAME_DATA(fd),
    .MPP_PIN_IN(mpp),
    .READ_DATA(rd),
    .PUMP_SWITCH_RATE_SEL(prate),
    .REGULATOR_PEAK_THRESHOLD_SEL(peak),
    .SPREAD_MODULATION_RATE(spread),
    .LEVEL1_LOCKED(lk1),
    .PIN_MODE(pmode),
    .FAIL_OUTPUT_EN(fo),
    .TIMER_SWITCH_EN(ts),
    .WAKE_INPUT_EN(wi),
    .HIGH_SIDE_SWITCH_ON(hs),
    .LOW_SIDE_SWITCH_ON(ls),
    .WAKE_EVENT(wev),
    .FAIL_SAFE_WAKE(fsw)
  );

  // ==========================================================
  // clock, cycle ceiling well above the ~15k cycles needed
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen_v,
                       input logic [15:0] exp);
    n_compared++;
    if (seen_v !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
    end
  endtask : check

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // note the expectation first, the monitor pops it
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
    notes.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask : rd_reg

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr_reg

  // cycles until the next high-side rising edge, bounded
  task automatic hs_rise(output int cnt);
    logic p;
    cnt = 0;
    do begin
      p = hs;
      @(negedge clock);
      cnt++;
    end while (!(hs && !p) && cnt < 3000);
  endtask : hs_rise

  task automatic tally_and_finish();
    // a read whose answer never showed leaves a note behind
    check("notes_left", 16'(notes.size()), 16'h0000);
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // read monitor: answer lands one edge after the read frame
  always @(posedge clock) pend <= fv & ~fw;
  always @(negedge clock) begin
    if (pend && notes.size() > 0) check("read_data", rd, notes.pop_front());
  end

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    restart = 1'b0;
    soft_rst = 1'b0;
    fsafe = 1'b0;
    lock0 = 1'b0;
    mpp = 1'b0;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    // power-on values and an unmapped place
    rd_reg(ADDR_HW_CFG2, HW_CFG2_POR);
    rd_reg(ADDR_PIN_MODE, 8'h00);
    rd_reg(ADDR_SW_DUTY, 8'h00);
    rd_reg(ADDR_SW_RATE, 8'h00);
    rd_reg(7'h10, 8'h00);
    // legal pump rates only, reserved bit 1 written high
    for (int i = 0; i < 16; i++) begin
      k = 8'(i);
      v = rnd();
      v = {1'b0, k[3:2], v[0], k[1:0], 2'b10};
      wr_reg(ADDR_HW_CFG2, v);
      hw = v & 8'hFC;
      rd_reg(ADDR_HW_CFG2, hw);
      check("pump_cfg", {prate, peak, spread, 2'b00}, hw);
    end
    // duty before any switch mode, full on
    wr_reg(ADDR_SW_DUTY, 8'hFF);
    wr_reg(ADDR_SW_RATE, 8'h03);
    for (int i = 0; i < 8; i++) begin
      k = 8'(i);
      v = rnd();
      v[2:0] = k[2:0];
      wr_reg(ADDR_PIN_MODE, v);
      rd_reg(ADDR_PIN_MODE, k);
      repeat (300) @(negedge clock);
      check("mode_out", {pmode, fo, ts, wi, hs, ls},
            {k[2:0], k < 3, k == 3, k == 5, k == 7, k == 6});
    end
    // restart: switch mode to off, duty kept, rate bit 1 dropped
    @(negedge clock) restart = 1'b1;
    @(negedge clock) restart = 1'b0;
    rd_reg(ADDR_PIN_MODE, 8'h04);
    rd_reg(ADDR_SW_DUTY, 8'hFF);
    rd_reg(ADDR_SW_RATE, 8'h01);
    rd_reg(ADDR_HW_CFG2, hw);
    // soft reset: duty and rate cleared
    @(negedge clock) soft_rst = 1'b1;
    @(negedge clock) soft_rst = 1'b0;
    rd_reg(ADDR_SW_DUTY, 8'h00);
    rd_reg(ADDR_SW_RATE, 8'h00);
    rd_reg(ADDR_PIN_MODE, 8'h04);
    // level-0 lock refuses pin mode writes silently
    lock0 = 1'b1;
    wr_reg(ADDR_PIN_MODE, 8'h05);
    rd_reg(ADDR_PIN_MODE, 8'h04);
    lock0 = 1'b0;
    // period per rate code, half duty
    wr_reg(ADDR_SW_DUTY, 8'h80);
    wr_reg(ADDR_PIN_MODE, 8'h07);
    for (int r = 0; r < 4; r++) begin
      wr_reg(ADDR_SW_RATE, 8'(r));
      hs_rise(n);
      hs_rise(n);
      hs_rise(n);
      check("pwm_period", 16'(n), 16'(PWM_STEPS * STEPS[r]));
    end
    // wake filter timing, fail-safe wake source
    wr_reg(ADDR_PIN_MODE, 8'h05);
    fsafe = 1'b1;
    @(negedge clock) mpp = 1'b1;
    n = 0;
    while (!wev && n < 4000) begin
      @(negedge clock);
      n++;
    end
    seen = fsw;
    @(negedge clock) seen = seen | fsw;
    check("wake_delay", 16'(n >= WAKE_FILT_CYC && n <= WAKE_FILT_CYC + 6),
          16'h0001);
    check("fs_wake", 16'(seen), 16'h0001);
    fsafe = 1'b0;
    // level-1 lock engages at select rise, survives soft reset
    wr_reg(ADDR_HW_CFG2, 8'h35);
    check("lock1", 16'(lk1), 16'h0001);
    wr_reg(ADDR_HW_CFG2, 8'h40);
    rd_reg(ADDR_HW_CFG2, 8'h35);
    @(negedge clock) soft_rst = 1'b1;
    @(negedge clock) soft_rst = 1'b0;
    rd_reg(ADDR_HW_CFG2, 8'h35);
    // only power-on clears the lock
    @(negedge clock) reset = 1'b1;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    rd_reg(ADDR_HW_CFG2, HW_CFG2_POR);
    repeat (4) @(negedge clock);
    tally_and_finish();
  end
endmodule : test_config_lock_regs
`default_nettype wire
